// File: acq_trig_map.svh
// register map, field positions, reset values and sizes of the trigger sequencer
`ifndef ACQ_TRIG_MAP_SVH
`define ACQ_TRIG_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_LEVEL 8'h04
`define OFS_PRELEN 8'h08
`define OFS_POSTLEN 8'h0C
`define OFS_DELAY 8'h10
`define OFS_HOLDOFF 8'h14
`define OFS_AUTO 8'h18
`define OFS_STATUS 8'h1C
`define CTRL_INIT 0
`define CTRL_ARM_BYP 1
`define CTRL_B_BYP 2
`define CTRL_FALL 3
`define CTRL_AUTO 4
`define CTRL_DLY_B 5
`define CTRL_W 6
`define RST_CTRL 6'h06
`define RST_LEVEL 16'h8000
`define RST_PRELEN 5'h08
`define RST_POSTLEN 16'h0008
`define RST_DELAY 16'h0000
`define RST_HOLDOFF 16'h0004
`define RST_AUTO 16'h0100
`define SAMPLE_W 16
`define CNT_W 16
`define HIST_DEPTH 16
`define HIST_IW 4
`define PRE_W 5
`endif

// File: acq_trig_pkg.sv
// types shared by the trigger sequencer
`include "acq_trig_map.svh"
`default_nettype none
package acq_trig_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ARM = 7'h02,
      ST_FILL = 7'h04,
      ST_WAITA = 7'h08,
      ST_DELAY = 7'h10,
      ST_WAITB = 7'h20,
      ST_CAPT = 7'h40
   } seq_state_e;
   typedef struct packed {
      logic [`SAMPLE_W-1:0] data;
      logic timeZero;
      logic last;
   } rec_word_s;
endpackage : acq_trig_pkg
`default_nettype wire

// File: acq_trigger_sequencer.sv
// acquisition trigger sequencer with APB registers and record output buffer
//
// Summary of operation
// - with initiate off the sequencer sits idle and neither arms nor triggers.
// - with initiate on it waits for the arm event, or arms at once when arm bypass is set.
// - with the second stage bypassed and zero delay it fires on the first-stage event.
// - the accepted trigger is time zero and each record word is placed relative to it.
// - while waiting it samples on, keeping the latest samples for the pretrigger part.
// - after the trigger it keeps storing samples until the posttrigger part is full.
// - after a trigger further triggers are ignored until capture and holdoff are over.
// - in normal mode no record is captured while no trigger occurs.
// - in auto mode an untriggered record is still captured when the auto timeout runs out before any first-stage event.
// - the event is placed on the waveform by the programmed level and slope.
// - an edge event is a crossing of the level in the programmed direction.
// - the delay applies to the first or the second stage, never to both.
//
// The register offsets and the APB slave port are this design's own decisions.
`include "acq_trig_map.svh"
`default_nettype none
module acq_trigger_sequencer
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // digitized sample stream
   input wire logic sampleValid,
   input wire logic [`SAMPLE_W-1:0] sampleData,
   output logic sampleReady,
   // event inputs from arm and second-stage detectors
   input wire logic armEvent,
   input wire logic stageBEvent,
   // record output stream
   output logic outValid,
   output acq_trig_pkg::rec_word_s outWord,
   input wire logic outReady
);
   logic [1:0] rstPipe;
   logic rstN;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rstPipe <= 2'h0;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstN = rstPipe[1];

   // registers
   logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic [`SAMPLE_W-1:0] level_reg, level_next;
   logic [`PRE_W-1:0] preLen_reg, preLen_next;
   logic [`CNT_W-1:0] postLen_reg, postLen_next;
   logic [`CNT_W-1:0] delay_reg, delay_next;
   logic [`CNT_W-1:0] holdoff_reg, holdoff_next;
   logic [`CNT_W-1:0] autoTo_reg, autoTo_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] statusWord;
   logic access;
   logic mapped;
   logic wrEn;

   assign access = psel && penable && !pready_reg;
   assign wrEn = psel && penable && pwrite && pready_reg;
   always_comb
   begin
      ctrl_next = ctrl_reg;
      level_next = level_reg;
      preLen_next = preLen_reg;
      postLen_next = postLen_reg;
      delay_next = delay_reg;
      holdoff_next = holdoff_reg;
      autoTo_next = autoTo_reg;
      prdata_next = 32'h0;
      pslverr_next = 1'b0;
      pready_next = access;
      mapped = 1'b1;
      case (paddr)
         `OFS_CTRL: prdata_next = {26'h0, ctrl_reg};
         `OFS_LEVEL: prdata_next = {16'h0, level_reg};
         `OFS_PRELEN: prdata_next = {27'h0, preLen_reg};
         `OFS_POSTLEN: prdata_next = {16'h0, postLen_reg};
         `OFS_DELAY: prdata_next = {16'h0, delay_reg};
         `OFS_HOLDOFF: prdata_next = {16'h0, holdoff_reg};
         `OFS_AUTO: prdata_next = {16'h0, autoTo_reg};
         `OFS_STATUS: prdata_next = statusWord;
         default: mapped = 1'b0;
      endcase
      if (!access || pwrite)
         prdata_next = 32'h0;
      pslverr_next = access && !mapped;
      // a write lands at the edge where the master sees pready, not one edge earlier
      if (wrEn)
      begin
         case (paddr)
            `OFS_CTRL: ctrl_next = pwdata[`CTRL_W-1:0];
            `OFS_LEVEL: level_next = pwdata[`SAMPLE_W-1:0];
            // a pretrigger length beyond the history depth is clipped to it
            `OFS_PRELEN: preLen_next = (pwdata[`PRE_W-1:0] > 5'h10) ? 5'h10
                                       : pwdata[`PRE_W-1:0];
            `OFS_POSTLEN: postLen_next = pwdata[`CNT_W-1:0];
            `OFS_DELAY: delay_next = pwdata[`CNT_W-1:0];
            `OFS_HOLDOFF: holdoff_next = pwdata[`CNT_W-1:0];
            `OFS_AUTO: autoTo_next = pwdata[`CNT_W-1:0];
            default: ctrl_next = ctrl_reg;
         endcase
      end
   end

   // history, sequencer and buffer state
   acq_trig_pkg::seq_state_e state_reg, state_next;
   logic [`HIST_IW-1:0] wrIdx_reg, wrIdx_next;
   logic [`SAMPLE_W-1:0] histReg [`HIST_DEPTH];
   logic [`SAMPLE_W-1:0] histNext [`HIST_DEPTH];
   logic [`SAMPLE_W-1:0] prevSample_reg, prevSample_next;
   logic [`CNT_W-1:0] cnt_reg, cnt_next;
   logic [`CNT_W-1:0] hold_reg, hold_next;
   logic [`CNT_W-1:0] recLeft_reg, recLeft_next;
   logic [`CNT_W-1:0] recIdx_reg, recIdx_next;
   logic [15:0] records_reg, records_next;
   logic lastTrig_reg, lastTrig_next;
   acq_trig_pkg::rec_word_s head_reg, head_next, tail_reg, tail_next;
   logic [1:0] count_reg, count_next;
   logic outValid_reg, outValid_next;
   logic inReady_reg, inReady_next;
   logic take;
   logic edgeA;
   logic holdBusy;
   logic push;
   logic pop;
   logic fire;
   logic fireTrig;
   logic [`SAMPLE_W-1:0] delayed;
   acq_trig_pkg::rec_word_s inWord;

   assign take = sampleValid && inReady_reg;
   assign holdBusy = (hold_reg != 16'h0);
   // edge crossing against the level, direction by slope bit
   assign edgeA = take && (ctrl_reg[`CTRL_FALL] ?
      (prevSample_reg > level_reg && sampleData <= level_reg) :
      (prevSample_reg < level_reg && sampleData >= level_reg));
   // delayed tap is read before the current sample overwrites its slot
   assign delayed = (preLen_reg == 5'h0) ? sampleData
      : histReg[wrIdx_reg - preLen_reg[`HIST_IW-1:0]];

   genvar g;
   generate
      for (g = 0; g < `HIST_DEPTH; g++)
      begin : gHist
         assign histNext[g] = (take && wrIdx_reg == 4'(g)) ? sampleData
                              : histReg[g];
         always_ff @(posedge clk or negedge rstN)
         begin
            if (!rstN)
               histReg[g] <= 16'h0;
            else
               histReg[g] <= histNext[g];
         end
      end
   endgenerate

   always_comb
   begin
      state_next = state_reg;
      wrIdx_next = take ? wrIdx_reg + 4'h1 : wrIdx_reg;
      prevSample_next = take ? sampleData : prevSample_reg;
      cnt_next = cnt_reg;
      hold_next = (holdBusy && take) ? hold_reg - 16'h1 : hold_reg;
      recLeft_next = recLeft_reg;
      recIdx_next = recIdx_reg;
      records_next = records_reg;
      lastTrig_next = lastTrig_reg;
      fire = 1'b0;
      fireTrig = 1'b0;
      push = 1'b0;
      case (state_reg)
         acq_trig_pkg::ST_IDLE:
            if (ctrl_reg[`CTRL_INIT] && !holdBusy)
               state_next = acq_trig_pkg::ST_ARM;
         acq_trig_pkg::ST_ARM:
            if (!ctrl_reg[`CTRL_INIT])
               state_next = acq_trig_pkg::ST_IDLE;
            else if (ctrl_reg[`CTRL_ARM_BYP] || armEvent)
            begin
               state_next = acq_trig_pkg::ST_FILL;
               cnt_next = 16'h0;
            end
         acq_trig_pkg::ST_FILL:
         begin
            if (take)
               cnt_next = cnt_reg + 16'h1;
            if (cnt_reg >= {11'h0, preLen_reg})
            begin
               state_next = acq_trig_pkg::ST_WAITA;
               cnt_next = autoTo_reg;
            end
         end
         acq_trig_pkg::ST_WAITA:
         begin
            if (take && cnt_reg != 16'h0)
               cnt_next = cnt_reg - 16'h1;
            if (edgeA)
            begin
               cnt_next = delay_reg;
               if (!ctrl_reg[`CTRL_DLY_B] && delay_reg != 16'h0)
                  state_next = acq_trig_pkg::ST_DELAY;
               else if (ctrl_reg[`CTRL_B_BYP] && delay_reg == 16'h0)
                  fireTrig = 1'b1;
               else if (ctrl_reg[`CTRL_B_BYP])
                  state_next = acq_trig_pkg::ST_DELAY;
               else
                  state_next = acq_trig_pkg::ST_WAITB;
            end
            else if (ctrl_reg[`CTRL_AUTO] && take && cnt_reg == 16'h1)
               fire = 1'b1;
            // in normal mode waiting lasts as long as no event comes
         end
         acq_trig_pkg::ST_WAITB:
            if (take && stageBEvent)
            begin
               if (ctrl_reg[`CTRL_DLY_B] && delay_reg != 16'h0)
                  state_next = acq_trig_pkg::ST_DELAY;
               else
                  fireTrig = 1'b1;
            end
         acq_trig_pkg::ST_DELAY:
            if (take)
            begin
               cnt_next = cnt_reg - 16'h1;
               if (cnt_reg == 16'h1)
               begin
                  if (!ctrl_reg[`CTRL_DLY_B] && !ctrl_reg[`CTRL_B_BYP])
                     state_next = acq_trig_pkg::ST_WAITB;
                  else
                     fireTrig = 1'b1;
               end
            end
         acq_trig_pkg::ST_CAPT:
            if (take)
            begin
               push = 1'b1;
               recLeft_next = recLeft_reg - 16'h1;
               recIdx_next = recIdx_reg + 16'h1;
               if (recLeft_reg == 16'h1)
               begin
                  // triggers are not looked at until holdoff runs out
                  state_next = acq_trig_pkg::ST_IDLE;
                  hold_next = holdoff_reg;
                  records_next = records_reg + 16'h1;
               end
            end
         default: state_next = acq_trig_pkg::ST_IDLE;
      endcase
      // dropping initiate abandons any wait for a trigger; a running capture completes
      if (!ctrl_reg[`CTRL_INIT] && state_reg != acq_trig_pkg::ST_CAPT)
         state_next = acq_trig_pkg::ST_IDLE;
      if ((fire || fireTrig) && ctrl_reg[`CTRL_INIT])
      begin
         // the firing sample is record word preLen; word 0, the delayed tap from preLen samples back, is pushed at once
         state_next = acq_trig_pkg::ST_CAPT;
         push = 1'b1;
         lastTrig_next = fireTrig;
         recLeft_next = {11'h0, preLen_reg} + postLen_reg - 16'h1;
         recIdx_next = 16'h1;
         if ({11'h0, preLen_reg} + postLen_reg <= 16'h1)
         begin
            state_next = acq_trig_pkg::ST_IDLE;
            hold_next = holdoff_reg;
            records_next = records_reg + 16'h1;
         end
      end
   end

   always_comb
   begin
      inWord.data = delayed;
      inWord.timeZero = (state_reg == acq_trig_pkg::ST_CAPT) ?
         (recIdx_reg == {11'h0, preLen_reg}) : (preLen_reg == 5'h0);
      inWord.last = (state_reg == acq_trig_pkg::ST_CAPT) ? (recLeft_reg == 16'h1)
         : ({11'h0, preLen_reg} + postLen_reg <= 16'h1);
   end

   // two-entry output buffer; input ready drops only when both slots are full
   assign pop = outValid_reg && outReady;
   always_comb
   begin
      head_next = head_reg;
      tail_next = tail_reg;
      count_next = count_reg;
      case ({push, pop})
         2'b10:
         begin
            if (count_reg == 2'h0)
               head_next = inWord;
            else
               tail_next = inWord;
            count_next = count_reg + 2'h1;
         end
         2'b01:
         begin
            head_next = tail_reg;
            count_next = count_reg - 2'h1;
         end
         2'b11:
            if (count_reg == 2'h1)
               head_next = inWord;
            else
            begin
               head_next = tail_reg;
               tail_next = inWord;
            end
         default: count_next = count_reg;
      endcase
      outValid_next = (count_next != 2'h0);
      inReady_next = (count_next != 2'h2);
   end

   assign statusWord = {records_reg, 7'h0, lastTrig_reg, 1'b0, state_reg};

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         ctrl_reg <= `RST_CTRL;
         level_reg <= `RST_LEVEL;
         preLen_reg <= `RST_PRELEN;
         postLen_reg <= `RST_POSTLEN;
         delay_reg <= `RST_DELAY;
         holdoff_reg <= `RST_HOLDOFF;
         autoTo_reg <= `RST_AUTO;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         state_reg <= acq_trig_pkg::ST_IDLE;
         wrIdx_reg <= 4'h0;
         prevSample_reg <= 16'h0;
         cnt_reg <= 16'h0;
         hold_reg <= 16'h0;
         recLeft_reg <= 16'h0;
         recIdx_reg <= 16'h0;
         records_reg <= 16'h0;
         lastTrig_reg <= 1'b0;
         head_reg <= '0;
         tail_reg <= '0;
         count_reg <= 2'h0;
         outValid_reg <= 1'b0;
         inReady_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         level_reg <= level_next;
         preLen_reg <= preLen_next;
         postLen_reg <= postLen_next;
         delay_reg <= delay_next;
         holdoff_reg <= holdoff_next;
         autoTo_reg <= autoTo_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         state_reg <= state_next;
         wrIdx_reg <= wrIdx_next;
         prevSample_reg <= prevSample_next;
         cnt_reg <= cnt_next;
         hold_reg <= hold_next;
         recLeft_reg <= recLeft_next;
         recIdx_reg <= recIdx_next;
         records_reg <= records_next;
         lastTrig_reg <= lastTrig_next;
         head_reg <= head_next;
         tail_reg <= tail_next;
         count_reg <= count_next;
         outValid_reg <= outValid_next;
         inReady_reg <= inReady_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sampleReady = inReady_reg;
   assign outValid = outValid_reg;
   assign outWord = head_reg;
endmodule : acq_trigger_sequencer
`default_nettype wire

// File: acq_trig_chk.sv
// port checker for the trigger sequencer
`default_nettype none
module acq_trig_chk
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // streams
   input wire logic sampleReady,
   input wire logic outValid,
   input wire acq_trig_pkg::rec_word_s outWord,
   input wire logic outReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] upReg;
   logic [1:0] upNext;
   logic inRecReg;
   logic inRecNext;
   logic pop;
   // reset leaves through two flops, so buffer flags are judged only from the fourth edge
   always_comb
   begin
      pop = outValid && outReady;
      upNext = upReg + {1'b0, upReg != 2'h3};
      inRecNext = (inRecReg || (pop && outWord.timeZero)) && !(pop && outWord.last);
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         upReg <= 2'h0;
         inRecReg <= 1'b0;
      end
      else
      begin
         upReg <= upNext;
         inRecReg <= inRecNext;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_ready_full: assert property (upReg == 2'h3 && !sampleReady |-> outValid)
      else $error("samples refused while buffer not full");
   a_ready_back: assert property (upReg == 2'h3 && !sampleReady && pop |=> sampleReady)
      else $error("samples still refused after a pop");
   a_hold_word: assert property (outValid && !outReady |=> outValid && $stable(outWord))
      else $error("record word lost during stall");
   a_tz_once: assert property (pop && outWord.timeZero |-> !inRecReg)
      else $error("second time zero inside one record");
   a_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("apb answer not after one wait cycle");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> psel && $past(penable))
      else $error("pready without access phase");
   a_rd_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   a_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h1C))
      else $error("error flag wrong for address");
   c_record: cover property (pop && outWord.last);
   c_full: cover property (upReg == 2'h3 && !sampleReady);
   c_err: cover property (pready && pslverr);
endmodule : acq_trig_chk
`default_nettype wire

// File: acq_sample_src.sv
// sample source standing in for the digitizer in front of the sequencer
`default_nettype none
module acq_sample_src
(
   // clock
   input wire logic clk,
   // sample stream
   input wire logic sampleReady,
   output logic sampleValid,
   output logic [15:0] sampleData,
   output logic stageBEvent
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [16:0] q[$];
   logic slow = 1'b0;
   initial
   begin
      sampleValid = 1'b0;
      sampleData = 16'h0000;
      stageBEvent = 1'b0;
   end
   task push(input logic [16:0] v);
      q.push_back(v);
   endtask : push
   // an offered sample stands until taken; idle data toggles so nothing stale looks valid
   always @(posedge clk)
   begin
      if (!sampleValid || sampleReady)
      begin
         if (sampleValid)
            void'(q.pop_front());
         if (q.size() != 0 && !(slow && $urandom_range(1) == 0))
         begin
            sampleValid <= 1'b1;
            sampleData <= q[0][15:0];
            stageBEvent <= q[0][16];
         end
         else
         begin
            sampleValid <= 1'b0;
            sampleData <= ~sampleData;
            stageBEvent <= 1'b0;
         end
      end
   end
endmodule : acq_sample_src
`default_nettype wire

// File: acquisition_trigger_sequencer_bench.sv
// bench for the trigger sequencer with a queue model of the record
`include "acq_trig_map.svh"
`default_nettype none
module acquisition_trigger_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sampleValid;
   logic [15:0] sampleData;
   logic sampleReady;
   logic armEvent = 1'b0;
   logic stageBEvent;
   logic outValid;
   acq_trig_pkg::rec_word_s outWord;
   logic outReady = 1'b0;
   logic stall = 1'b0;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int recs = 0;
   logic [15:0] seen[$];
   acq_trig_pkg::rec_word_s rec[$];
   logic [31:0] rv[9] = '{`RST_CTRL, `RST_LEVEL, `RST_PRELEN, `RST_POSTLEN, `RST_DELAY,
      `RST_HOLDOFF, `RST_AUTO, 32'h1, 32'h0};
   always #25 clk = ~clk;
   acq_trigger_sequencer dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sampleValid, .sampleData, .sampleReady, .armEvent,
      .stageBEvent, .outValid, .outWord, .outReady);
   acq_sample_src src (.clk, .sampleReady, .sampleValid, .sampleData, .stageBEvent);
   always @(posedge clk)
   begin
      cycles++;
      if (sampleValid && sampleReady)
         seen.push_back(sampleData);
      if (outValid && outReady)
         rec.push_back(outWord);
      outReady <= !stall && ($urandom_range(3) != 0);
      if (cycles == 6000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   task cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", s, e, g);
         miscompares++;
      end
   endtask : cmp
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no wait count here: only the bench timeout ends a hung access
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // crossing at k, trigger sample at tz, one dip right after it that must be ignored
   task run(input string s, input int p, input int n, input int k, input int tz,
      input bit fall, input bit bStage, input int nw);
      int base;
      int c;
      logic [15:0] r;
      base = seen.size();
      rec.delete();
      for (int i = 0; i < n; i++)
      begin
         r = 16'h8001 + 16'($urandom_range(255));
         if (((i >= k) && (i != tz + 1)) == fall)
            r = 16'hFFFF - r;
         src.push({bStage && (i == tz), r});
      end
      c = 0;
      while (src.q.size() != 0)
      begin
         @(posedge clk);
         c++;
         if (c == 60)
            stall <= 1'b0;
      end
      repeat (30) @(posedge clk);
      cmp({s, " words"}, 32'(nw), 32'(rec.size()));
      for (int i = 0; i < rec.size() && i < nw; i++)
      begin
         if (tz >= 0)
            cmp({s, " data"}, 32'(seen[base + tz - p + i]), 32'(rec[i].data));
         cmp({s, " zero"}, 32'(i == p), 32'(rec[i].timeZero));
         cmp({s, " last"}, 32'(i == nw - 1), 32'(rec[i].last));
      end
      if (nw > 0)
         recs++;
      $display("test %s done", s);
   endtask : run
   task give_verdict();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      void'($urandom(32'h7B2B8DA2));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         cmp("reset value", rv[i], rd);
         cmp("error flag", 32'(i == 8), 32'(err));
      end
      apb(1'b1, `OFS_PRELEN, 32'h14);
      apb(1'b0, `OFS_PRELEN, 32'h0);
      cmp("clipped length", 32'h10, rd);
      apb(1'b1, `OFS_PRELEN, 32'h4);
      apb(1'b1, `OFS_POSTLEN, 32'h4);
      run("idle", 4, 20, 8, 8, 0, 0, 0);
      apb(1'b1, `OFS_CTRL, 32'h5);
      run("arm wait", 4, 20, 8, 8, 0, 0, 0);
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp("arm state", 32'h2, 32'(rd[6:0]));
      armEvent <= 1'b1;
      repeat (2) @(posedge clk);
      armEvent <= 1'b0;
      apb(1'b1, `OFS_CTRL, 32'h7);
      run("rising", 4, 24, 8, 8, 0, 0, 8);
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp("triggered", 32'h1, 32'(rd[8]));
      apb(1'b1, `OFS_PRELEN, 32'h10);
      apb(1'b1, `OFS_CTRL, 32'hF);
      stall <= 1'b1;
      src.slow = 1'b1;
      run("falling", 16, 44, 20, 20, 1, 0, 20);
      src.slow = 1'b0;
      apb(1'b1, `OFS_PRELEN, 32'h4);
      apb(1'b1, `OFS_CTRL, 32'h7);
      run("quiet", 4, 40, 40, -1, 0, 0, 0);
      apb(1'b1, `OFS_AUTO, 32'h14);
      // dropping initiate and setting it again re-arms, which reloads the auto count
      apb(1'b1, `OFS_CTRL, 32'h16);
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp("init off", 32'h1, 32'(rd[6:0]));
      apb(1'b1, `OFS_CTRL, 32'h17);
      run("auto", 4, 40, 40, -1, 0, 0, 8);
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp("untriggered", 32'h0, 32'(rd[8]));
      apb(1'b1, `OFS_CTRL, 32'h3);
      run("second stage", 4, 26, 8, 11, 0, 1, 8);
      apb(1'b0, `OFS_STATUS, 32'h0);
      cmp("record count", 32'(recs), 32'(rd[31:16]));
      give_verdict();
   end
endmodule : acquisition_trigger_sequencer_bench
bind acq_trigger_sequencer acq_trig_chk chk (.clk, .reset_n, .psel, .penable, .paddr, .prdata,
   .pready, .pslverr, .sampleReady, .outValid, .outWord, .outReady);
`default_nettype wire
